// ==== src/node_opts_defs.vh ====
// register offsets, field positions and reset values of the node options block
`ifndef NODE_OPTS_DEFS_VH
`define NODE_OPTS_DEFS_VH

`define ADDR_W 8
`define OPTS_OFF 8'h20
`define STAT_OFF 8'h40
`define CTRL_OFF 8'h44

`define RM_CAP_BIT 31
`define CM_CAP_BIT 30
`define ISO_CAP_BIT 29
`define BM_CAP_BIT 28
`define PM_CAP_BIT 27
`define ACC_HI 23
`define ACC_LO 16
`define REQ_HI 15
`define REQ_LO 12
`define GEN_HI 7
`define GEN_LO 6
`define SPD_HI 2
`define SPD_LO 0

`define CAP_RST 5'h00
`define ACC_RST 8'h00
`define REQ_RST 4'hA
`define REQ_MIN 4'h8
`define GEN_RST 2'h0
`define LINK_SPD 3'h2

`define ST_DIRTY_BIT 0
`define ST_LINK_BIT 1
`define ST_OVER_BIT 2
`define ST_EDIT_BIT 3

`define CT_SRST_BIT 0
`define CT_CHK_BIT 1
`define CHK_EN_RST 1'b1

`define FULL_BE 4'hF
`define LEN_W 16

`endif

// ==== src/pin_sync.v ====
// two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire sys_clk_i, // register clock
  input wire rst_n_i, // async reset, active low
  input wire [WIDTH-1:0] pin_i, // raw asynchronous pins
  output wire [WIDTH-1:0] sync_o // pins after two flops
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : bit_sync
      always @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
        end
        else
        begin
          stage1[g] <= pin_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign sync_o = stage2;
endmodule

// ==== src/blk_len_check.v ====
// block write length check against the byte limit of the request size code
`timescale 1ns/1ps
`include "node_opts_defs.vh"
module blk_len_check (
  input wire sys_clk_i, // register clock
  input wire rst_n_i, // async reset, active low
  input wire enable_i, // check enabled
  input wire [3:0] code_i, // request size code
  input wire valid_i, // block write header seen
  input wire [`LEN_W-1:0] len_i, // block write length in bytes
  output reg over_o // one-cycle pulse: length above limit
);
  // code 15 gives 65536, one bit wider than any length can be
  wire [`LEN_W:0] limit;
  wire [4:0] shift;

  assign shift = {1'b0, code_i} + 5'h01;
  assign limit = {{`LEN_W{1'b0}}, 1'b1} << shift;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      over_o <= 1'b0;
    else
      over_o <= enable_i && valid_i && ({1'b0, len_i} > limit);
  end
endmodule

// ==== src/node_bus_options.v ====
// node bus options register with Avalon-MM slave, generation tracking and length check
`timescale 1ns/1ps
`include "node_opts_defs.vh"

module node_bus_options (
  input wire sys_clk_i, // register clock, 10 MHz
  input wire rst_n_i, // hardware reset, async, active low
  input wire [`ADDR_W-1:0] address_i, // avalon byte address
  input wire read_i, // avalon read
  input wire write_i, // avalon write
  input wire [31:0] writedata_i, // avalon write data
  input wire [3:0] byteenable_i, // avalon byte enables
  output reg [31:0] readdata_o, // avalon read data
  output wire waitrequest_o, // avalon wait
  input wire soft_rst_i, // software reset pulse, same clock
  input wire link_on_switch_i, // link enable from control register
  input wire bus_reset_pin_i, // bus reset indication from the phy
  input wire rom_changed_i, // config ROM write pulse, same clock
  input wire blk_wr_valid_i, // block write header pulse
  input wire [`LEN_W-1:0] blk_wr_len_i, // block write length
  output wire ack_type_error_o, // answer type error, one pulse
  output reg [31:0] bus_info_q2_o // second bus info quadlet
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  localparam SEL_NONE = 3'b000;
  localparam SEL_OPTS = 3'b001;
  localparam SEL_STAT = 3'b010;
  localparam SEL_CTRL = 3'b100;

  reg [1:0] state;
  reg [1:0] next_state;

  reg [4:0] cap_flags;
  reg [7:0] clk_acc;
  reg [3:0] max_req_code;
  reg [1:0] gen_count;
  reg rom_dirty;
  reg over_seen;
  reg edit_linked;
  reg chk_en;
  reg bus_rst_prev;

  reg [4:0] next_cap_flags;
  reg [7:0] next_clk_acc;
  reg [3:0] next_max_req_code;
  reg [1:0] next_gen_count;
  reg next_rom_dirty;
  reg next_over_seen;
  reg next_edit_linked;
  reg next_chk_en;

  wire bus_rst_sync;
  wire bus_rst_rise;
  wire req;
  wire wr_take;
  wire full_word;
  wire [2:0] rd_sel;
  wire [2:0] wr_sel;
  wire opts_wr;
  wire stat_wr;
  wire ctrl_wr;
  wire sw_rst;
  wire over_pulse;
  wire [31:0] opts_word;
  wire [31:0] stat_word;
  wire [31:0] ctrl_word;
  wire [3:0] wr_req_code;

  // one decoder shared by the read and write paths
  function [2:0] decode_addr;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OPTS_OFF: decode_addr = SEL_OPTS;
        `STAT_OFF: decode_addr = SEL_STAT;
        `CTRL_OFF: decode_addr = SEL_CTRL;
        default: decode_addr = SEL_NONE;
      endcase
    end
  endfunction

  pin_sync #(
    .WIDTH(1)
  ) u_bus_rst_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(bus_reset_pin_i),
    .sync_o(bus_rst_sync)
  );

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_rst_prev <= 1'b0;
    else
      bus_rst_prev <= bus_rst_sync;
  end

  // prev resets to the idle level of the pin, so no false edge follows reset
  assign bus_rst_rise = bus_rst_sync && !bus_rst_prev;

  // the check sees the live size code, not the lagged external image
  blk_len_check u_len_check (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(chk_en),
    .code_i(max_req_code),
    .valid_i(blk_wr_valid_i),
    .len_i(blk_wr_len_i),
    .over_o(over_pulse)
  );

  assign ack_type_error_o = over_pulse;

  // every access costs one wait cycle; read data is built in the idle cycle
  assign req = read_i || write_i;
  assign waitrequest_o = req && (state != ST_ACK);
  assign wr_take = write_i && (state == ST_ACK);
  assign full_word = (byteenable_i == `FULL_BE);
  assign rd_sel = decode_addr(address_i);
  assign wr_sel = decode_addr(address_i);
  assign opts_wr = wr_take && full_word && (wr_sel == SEL_OPTS);
  assign stat_wr = wr_take && full_word && (wr_sel == SEL_STAT);
  assign ctrl_wr = wr_take && full_word && (wr_sel == SEL_CTRL);
  assign sw_rst = soft_rst_i || (ctrl_wr && writedata_i[`CT_SRST_BIT]);
  assign wr_req_code = writedata_i[`REQ_HI:`REQ_LO];

  assign opts_word = {cap_flags,
                      3'h0,
                      clk_acc,
                      max_req_code,
                      4'h0,
                      gen_count,
                      3'h0,
                      `LINK_SPD};

  // status: rom dirty, link level, overlength and edited-while-linked stickies
  assign stat_word = {28'h0000000, edit_linked, over_seen,
                      link_on_switch_i, rom_dirty};
  // the soft reset strobe always reads back as zero
  assign ctrl_word = {30'h0000000, chk_en, 1'b0};

  // idle, then one acknowledge cycle per access
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (req)
          next_state = ST_ACK;
      ST_ACK:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      readdata_o <= 32'h00000000;
    else if (state == ST_IDLE && read_i)
    begin
      case (rd_sel)
        SEL_OPTS: readdata_o <= opts_word;
        SEL_STAT: readdata_o <= stat_word;
        SEL_CTRL: readdata_o <= ctrl_word;
        default: readdata_o <= 32'h00000000;
      endcase
    end
  end

  // capability flags and clock accuracy
  always @*
  begin
    next_cap_flags = cap_flags;
    next_clk_acc = clk_acc;
    if (opts_wr)
    begin
      next_cap_flags = writedata_i[`RM_CAP_BIT:`PM_CAP_BIT];
      next_clk_acc = writedata_i[`ACC_HI:`ACC_LO];
    end
    if (sw_rst)
    begin
      next_cap_flags = `CAP_RST;
      next_clk_acc = `ACC_RST;
    end
  end

  // a software reset never reaches this field
  always @*
  begin
    next_max_req_code = max_req_code;
    // codes under the 512 byte floor are refused, the field keeps its value
    if (opts_wr && (wr_req_code >= `REQ_MIN))
      next_max_req_code = wr_req_code;
  end

  // generation counter and the rom change flag behind it
  always @*
  begin
    next_gen_count = gen_count;
    next_rom_dirty = rom_dirty;
    if (opts_wr)
      next_gen_count = writedata_i[`GEN_HI:`GEN_LO];
    // a change since the last bus reset advances the count at the next one
    if (bus_rst_rise && rom_dirty)
      next_gen_count = next_gen_count + 2'h1;
    if (bus_rst_rise)
      next_rom_dirty = 1'b0;
    if (rom_changed_i)
      next_rom_dirty = 1'b1;
    if (sw_rst)
    begin
      next_gen_count = `GEN_RST;
      next_rom_dirty = 1'b0;
    end
  end

  // status stickies: a set in the same cycle as its clear wins
  always @*
  begin
    next_over_seen = over_seen;
    next_edit_linked = edit_linked;
    if (stat_wr && writedata_i[`ST_OVER_BIT])
      next_over_seen = 1'b0;
    if (over_pulse)
      next_over_seen = 1'b1;
    // flags edits made while the link runs, which the host must avoid
    if (stat_wr && writedata_i[`ST_EDIT_BIT])
      next_edit_linked = 1'b0;
    if (opts_wr && link_on_switch_i)
      next_edit_linked = 1'b1;
    if (sw_rst)
    begin
      next_over_seen = 1'b0;
      next_edit_linked = 1'b0;
    end
  end

  // check enable comes back on with either reset
  always @*
  begin
    next_chk_en = chk_en;
    if (ctrl_wr)
      next_chk_en = writedata_i[`CT_CHK_BIT];
    if (sw_rst)
      next_chk_en = `CHK_EN_RST;
  end

  // capability flags and accuracy clear on both resets
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cap_flags <= `CAP_RST;
      clk_acc <= `ACC_RST;
    end
    else
    begin
      cap_flags <= next_cap_flags;
      clk_acc <= next_clk_acc;
    end
  end

  // only a hardware reset reloads the size code
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      max_req_code <= `REQ_RST;
    else
      max_req_code <= next_max_req_code;
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gen_count <= `GEN_RST;
      rom_dirty <= 1'b0;
    end
    else
    begin
      gen_count <= next_gen_count;
      rom_dirty <= next_rom_dirty;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      over_seen <= 1'b0;
      edit_linked <= 1'b0;
    end
    else
    begin
      over_seen <= next_over_seen;
      edit_linked <= next_edit_linked;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chk_en <= `CHK_EN_RST;
    else
      chk_en <= next_chk_en;
  end

  // external image lags the register by one cycle
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_info_q2_o <= 32'h00000000;
    else
      bus_info_q2_o <= opts_word;
  end
endmodule

// ==== verification/node_opts_properties.sv ====
// port assertions for the node bus options register
`timescale 1ns/1ps
`include "node_opts_defs.vh"
module node_opts_properties (
  input wire sys_clk_i, // clock
  input wire rst_n_i, // hardware reset
  input wire [`ADDR_W-1:0] address_i, // address
  input wire read_i, // read
  input wire write_i, // write
  input wire [31:0] writedata_i, // write data
  input wire [3:0] byteenable_i, // byte enables
  input wire [31:0] readdata_o, // read data
  input wire waitrequest_o, // wait
  input wire soft_rst_i, // software reset
  input wire link_on_switch_i, // link enable
  input wire bus_reset_pin_i, // bus reset
  input wire rom_changed_i, // rom changed
  input wire blk_wr_valid_i, // block write
  input wire [`LEN_W-1:0] blk_wr_len_i, // block length
  input wire ack_type_error_o, // type error
  input wire [31:0] bus_info_q2_o // options copy
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [3:0] code = bus_info_q2_o[15:12];
  // limit needs 17 bits for the largest code
  wire [31:0] limit = 32'h1 << ({28'h0, code} + 32'h1);
  // check enable as the design should hold it, from accepted control writes
  wire ctrl_acc = write_i && !waitrequest_o && (address_i == `CTRL_OFF)
    && (byteenable_i == `FULL_BE);
  reg chk_model;
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      chk_model <= `CHK_EN_RST;
    else if (soft_rst_i || (ctrl_acc && writedata_i[`CT_SRST_BIT]))
      chk_model <= 1'b1;
    else if (ctrl_acc)
      chk_model <= writedata_i[`CT_CHK_BIT];
  end
  a_speed_code: assert property ($past(rst_n_i, 2) |-> bus_info_q2_o[2:0] == 3'h2)
    else $error("speed code wrong");
  a_reserved_zero: assert property ($past(rst_n_i, 2) |-> bus_info_q2_o[26:24] == 3'h0
    && bus_info_q2_o[11:8] == 4'h0 && bus_info_q2_o[5:3] == 3'h0)
    else $error("reserved bits set");
  a_code_floor: assert property ($past(rst_n_i, 2) |-> code >= 4'h8)
    else $error("size code below floor");
  a_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer late");
  a_err_len: assert property (blk_wr_valid_i && $past(rst_n_i, 2) |=>
    ack_type_error_o == ($past(chk_model) && ({16'h0, $past(blk_wr_len_i)} > limit)))
    else $error("type error mismatch");
  a_err_cause: assert property (ack_type_error_o |-> $past(blk_wr_valid_i))
    else $error("type error without request");
  a_soft_code: assert property (soft_rst_i && !write_i |=> ##1 $stable(code))
    else $error("size code lost on soft reset");
  a_soft_clear: assert property (soft_rst_i && !write_i |=> ##1
    bus_info_q2_o[31:27] == 5'h0 && bus_info_q2_o[23:16] == 8'h0)
    else $error("soft reset left fields");
  a_gen_step: assert property ($changed(bus_info_q2_o[7:6]) && !$past(write_i, 2)
    && !$past(soft_rst_i, 2) |-> bus_info_q2_o[7:6] == $past(bus_info_q2_o[7:6]) + 2'h1)
    else $error("generation jumped");
endmodule
bind node_bus_options node_opts_properties u_props (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .soft_rst_i(soft_rst_i),
  .link_on_switch_i(link_on_switch_i), .bus_reset_pin_i(bus_reset_pin_i),
  .rom_changed_i(rom_changed_i), .blk_wr_valid_i(blk_wr_valid_i),
  .blk_wr_len_i(blk_wr_len_i), .ack_type_error_o(ack_type_error_o),
  .bus_info_q2_o(bus_info_q2_o)
);

// ==== verification/node_bus_options_tb.sv ====
// self-checking bench for the node bus options register
`timescale 1ns/1ps
`include "node_opts_defs.vh"
module node_bus_options_tb;
  reg sys_clk_i = 1'h0;
  reg rst_n_i = 1'h0;
  reg read_i = 1'h0;
  reg write_i = 1'h0;
  reg soft_rst_i = 1'h0;
  reg link_on_switch_i = 1'h0;
  reg bus_reset_pin_i = 1'h0;
  reg rom_changed_i = 1'h0;
  reg blk_wr_valid_i = 1'h0;
  reg [`ADDR_W-1:0] address_i = 8'h00;
  reg [31:0] writedata_i = 32'h0;
  reg [3:0] byteenable_i = 4'hF;
  reg [`LEN_W-1:0] blk_wr_len_i = 16'h0;
  wire [31:0] readdata_o;
  wire waitrequest_o;
  wire ack_type_error_o;
  wire [31:0] bus_info_q2_o;
  reg [31:0] rd;
  integer fail_count = 0;
  integer num_checks = 0;
  integer i;
  always #50 sys_clk_i = ~sys_clk_i;
  node_bus_options DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .soft_rst_i(soft_rst_i),
    .link_on_switch_i(link_on_switch_i), .bus_reset_pin_i(bus_reset_pin_i),
    .rom_changed_i(rom_changed_i), .blk_wr_valid_i(blk_wr_valid_i),
    .blk_wr_len_i(blk_wr_len_i), .ack_type_error_o(ack_type_error_o),
    .bus_info_q2_o(bus_info_q2_o)
  );
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // one access with the given byte enables; read data taken at the edge that ends the wait
  task bus(input wr, input [7:0] a, input [31:0] d, input [3:0] be);
    integer n;
  begin
    @(posedge sys_clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    n = 0;
    @(posedge sys_clk_i);
    while (waitrequest_o !== 1'h0 && n < 50)
    begin
      n = n + 1;
      @(posedge sys_clk_i);
    end
    if (n == 50)
      fail_count = fail_count + 1;
    rd = readdata_o;
    read_i <= 1'h0;
    write_i <= 1'h0;
  end
  endtask
  task len_chk(input [15:0] len, input err);
  begin
    @(posedge sys_clk_i);
    blk_wr_valid_i <= 1'h1;
    blk_wr_len_i <= len;
    @(posedge sys_clk_i);
    blk_wr_valid_i <= 1'h0;
    @(posedge sys_clk_i);
    chk({31'h0, ack_type_error_o}, {31'h0, err});
  end
  endtask
  task hw_reset;
  begin
    rst_n_i <= 1'h0;
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
  end
  endtask
  task results;
  begin
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count = fail_count + 1;
    results;
  end
  initial
  begin
    hw_reset;
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h0000A002);
    len_chk(16'h0800, 1'h0);
    len_chk(16'h0801, 1'h1);
    bus(1'h1, `OPTS_OFF, 32'hFFFFFFFF, 4'hF);
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'hF8FFF0C2);
    chk(bus_info_q2_o, 32'hF8FFF0C2);
    bus(1'h1, `OPTS_OFF, 32'h50AB8000, 4'hF);
    bus(1'h1, `OPTS_OFF, 32'hFFFFFFFF, 4'h3);
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h50AB8002);
    len_chk(16'h0200, 1'h0);
    len_chk(16'h0201, 1'h1);
    bus(1'h1, `OPTS_OFF, 32'h07000000, 4'hF);
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00008002);
    bus(1'h0, 8'h10, 32'h0, 4'hF);
    chk(rd, 32'h0);
    bus(1'h1, `OPTS_OFF, 32'hA8CD90C0, 4'hF);
    @(posedge sys_clk_i);
    soft_rst_i <= 1'h1;
    @(posedge sys_clk_i);
    soft_rst_i <= 1'h0;
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00009002);
    link_on_switch_i <= 1'h1;
    // second bus reset comes without a rom change, so no step
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge sys_clk_i);
      rom_changed_i <= (i == 0);
      @(posedge sys_clk_i);
      rom_changed_i <= 1'h0;
      bus_reset_pin_i <= 1'h1;
      repeat (4) @(posedge sys_clk_i);
      bus_reset_pin_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
      chk(rd, 32'h00009042);
    end
    len_chk(16'h0401, 1'h1);
    // same field values while the link runs still set the edited-while-linked sticky
    bus(1'h1, `OPTS_OFF, 32'h00009040, 4'hF);
    bus(1'h0, `STAT_OFF, 32'h0, 4'hF);
    chk(rd, 32'h0000000E);
    bus(1'h1, `STAT_OFF, 32'h0000000C, 4'hF);
    bus(1'h0, `STAT_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00000002);
    link_on_switch_i <= 1'h0;
    bus(1'h1, `CTRL_OFF, 32'h00000000, 4'hF);
    len_chk(16'hFFFF, 1'h0);
    bus(1'h0, `CTRL_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    bus(1'h1, `CTRL_OFF, 32'h00000001, 4'hF);
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00009002);
    bus(1'h0, `CTRL_OFF, 32'h0, 4'hF);
    chk(rd, 32'h00000002);
    len_chk(16'h0401, 1'h1);
    hw_reset;
    bus(1'h0, `OPTS_OFF, 32'h0, 4'hF);
    chk(rd, 32'h0000A002);
    results;
  end
endmodule
